// ---- common/hbcsp_pkg.sv ----
`default_nettype none
package hbcsp_pkg;

   // ----------------------------------------------------------------
   // Command/address byte layout
   // ----------------------------------------------------------------
   localparam int CMD_MSB = 7;
   localparam int CMD_LSB = 4;
   localparam int ADDR_MSB = 3;
   localparam int ADDR_LSB = 0;
   localparam int UNDEF_BIT = 3;

   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_BYTE_READ = 4'h7;
   localparam logic [3:0] CMD_INT_UNMASK = 4'h6;
   localparam logic [3:0] CMD_INT_MASK = 4'h5;
   localparam logic [3:0] CMD_BEGIN_TRANS = 4'h4;
   localparam logic [3:0] CMD_IDENTITY_READ = 4'h3;
   localparam logic [3:0] CMD_BYTE_WRITE = 4'h2;
   localparam logic [3:0] CMD_STATUS_READ = 4'h1;
   localparam logic [3:0] CMD_RESET = 4'h0;

   // ----------------------------------------------------------------
   // Reset values and fixed bytes
   // ----------------------------------------------------------------
   localparam logic MASK_RST = 1'b1;
   localparam logic SELECT_RST = 1'b0;
   localparam logic FLAG_RST = 1'b0;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] INVALID_FILL = 8'h00;
   // Identification byte; the value is arbitrary
   localparam logic [7:0] IDENTITY_BYTE = 8'h5a;

   // ----------------------------------------------------------------
   // Sync widths
   // ----------------------------------------------------------------
   localparam int PIN_W = 19;
   localparam int STRAP_W = 5;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   // Controller state presented by the sequencer
   typedef struct packed {
      logic dir;
      logic busy;
      logic cmdData;
      logic message_phase;
      logic req;
      logic selftest;
   } hbcsp_seq_stat_t;

   // Interface status latch, bit 7 first
   typedef struct packed {
      logic dir;
      logic busy;
      logic cmdData;
      logic message_phase;
      logic req;
      logic invalid;
      logic parity;
      logic selftest;
   } hbcsp_status_t;

   // Interrupt response byte, bit 7 first
   typedef struct packed {
      logic dir;
      logic err;
      logic cmdData;
      logic message_phase;
      logic [3:0] unit;
   } hbcsp_resp_t;

   // Decoded bus phase from bits 7, 5 and 4
   typedef enum logic [2:0] {
      PH_NONE,
      PH_NEXT_CMD,
      PH_OUT_DATA,
      PH_IN_DATA,
      PH_COMPLETION,
      PH_MESSAGE
   } hbcsp_phase_t;

   // Data line driver state
   typedef enum logic [1:0] {
      DS_IDLE,
      DS_DRIVE,
      DS_RESP
   } hbcsp_state_t;

endpackage
`default_nettype wire

// ---- dv/hbcsp_host_model.sv ----
`default_nettype none
module hbcsp_host_model (
   // Clock
   input wire logic sys_clk,
   // Host pins
   output logic [7:0] cmdAddrPin,
   output logic cmdParityPin,
   output logic strobe1Pin,
   output logic strobe2Pin,
   output logic [7:0] dataInPin,
   output logic intAckPin
);
   timeunit 1ns;
   timeprecision 1ps;
   int sinceRst = 9999;

   // Idle pin levels
   initial begin
      cmdAddrPin = 8'h00;
      cmdParityPin = 1'b1;
      strobe1Pin = 1'b0;
      strobe2Pin = 1'b0;
      dataInPin = 8'h00;
      intAckPin = 1'b0;
   end

   // Time since the last reset command
   always @(posedge sys_clk) sinceRst <= sinceRst + 1;

   // Command set up, then strobe raised and held
   task automatic issue(input logic [7:0] ca, input logic [7:0] data, input logic bad,
      input logic alt);
      @(negedge sys_clk);
      while (ca[7:4] == hbcsp_pkg::CMD_BEGIN_TRANS && sinceRst < 2500) @(negedge sys_clk);
      cmdAddrPin = ca;
      cmdParityPin = ~^{ca, bad};
      dataInPin = data;
      repeat (3) @(negedge sys_clk);
      if (alt) strobe2Pin = 1'b1;
      else strobe1Pin = 1'b1;
      repeat (7) @(negedge sys_clk);
   endtask

   // Strobe dropped, bus lines no longer hold their value
   task automatic release_bus();
      if (cmdAddrPin[7:4] == hbcsp_pkg::CMD_RESET) sinceRst = 0;
      strobe1Pin = 1'b0;
      strobe2Pin = 1'b0;
      cmdAddrPin = ~cmdAddrPin;
      dataInPin = ~dataInPin;
      repeat (5) @(negedge sys_clk);
   endtask

   // Interrupt acknowledge level held for a while
   task automatic set_ack(input logic v);
      @(negedge sys_clk);
      intAckPin = v;
      repeat (6) @(negedge sys_clk);
   endtask
endmodule
`default_nettype wire

// ---- dv/hbcsp_port_monitor.sv ----
`default_nettype none
module hbcsp_port_monitor (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Host side
   input wire logic strobe1Pin,
   input wire logic intAckPin,
   input wire logic [7:0] dataOut,
   input wire logic dataOe,
   input wire logic intReqOut,
   // Sequencer side
   input wire hbcsp_pkg::hbcsp_seq_stat_t seqStat,
   input wire logic [7:0] seqRdByte,
   input wire logic seqIntEvent,
   input wire logic seqSelClear,
   input wire logic wrStrobe,
   input wire logic rdStrobe,
   input wire logic selectLatch,
   input wire logic softReset,
   input wire logic intMasked,
   input wire logic endOfOp,
   input wire hbcsp_pkg::hbcsp_phase_t phase,
   input wire hbcsp_pkg::hbcsp_status_t statusLatch
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   // Response byte held while the host acknowledges
   sequence ackHeld;
      intReqOut && dataOe && intAckPin [*3];
   endsequence

   reset_mask_a: assert property ($rose(rstn) |-> intMasked && !selectLatch)
      else $error("mask or select wrong after reset");
   soft_reset_a: assert property (softReset |-> ##[0:1] (intMasked && !selectLatch))
      else $error("reset command left state behind");
   wr_request_a: assert property (wrStrobe |-> $past(seqStat.req))
      else $error("write passed without byte request");
   rd_byte_a: assert property (rdStrobe |-> dataOe && dataOut == $past(seqRdByte))
      else $error("read byte not driven");
   end_op_a: assert property (endOfOp |-> rdStrobe && $past(seqStat.message_phase && seqStat.dir))
      else $error("end of operation without ending byte");
   phase_idle_a: assert property (!seqStat.req |-> phase == hbcsp_pkg::PH_NONE)
      else $error("phase shown without request");
   phase_msg_a: assert property (
      seqStat.req && seqStat.dir && seqStat.cmdData && seqStat.message_phase
      |-> phase == hbcsp_pkg::PH_MESSAGE) else $error("message phase not decoded");
   busy_bit_a: assert property (
      statusLatch.busy == seqStat.busy && statusLatch.selftest == seqStat.selftest)
      else $error("status busy or selftest bit wrong");
   sel_clear_a: assert property (seqSelClear && !strobe1Pin |=> !selectLatch)
      else $error("select latch not cleared");
   int_unmask_a: assert property (seqIntEvent && !intMasked |=> intReqOut)
      else $error("unmasked event gave no request");
   ack_clear_a: assert property (
      ackHeld ##1 !intAckPin |-> ##[1:5] (!intReqOut && !dataOe))
      else $error("request not cleared after acknowledge");
endmodule

bind hbcsp_port hbcsp_port_monitor u_mon (
   .sys_clk(sys_clk), .rstn(rstn), .strobe1Pin(strobe1Pin), .intAckPin(intAckPin),
   .dataOut(dataOut), .dataOe(dataOe), .intReqOut(intReqOut), .seqStat(seqStat),
   .seqRdByte(seqRdByte), .seqIntEvent(seqIntEvent), .seqSelClear(seqSelClear),
   .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .selectLatch(selectLatch),
   .softReset(softReset), .intMasked(intMasked), .endOfOp(endOfOp), .phase(phase),
   .statusLatch(statusLatch)
);
`default_nettype wire

// ---- dv/hbcsp_port_test.sv ----
`default_nettype none
module hbcsp_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] UNIT = 4'ha;
   localparam logic [7:0] C_ID = {hbcsp_pkg::CMD_IDENTITY_READ, UNIT};
   localparam logic [7:0] C_BEG = {hbcsp_pkg::CMD_BEGIN_TRANS, UNIT};
   localparam logic [7:0] C_UNM = {hbcsp_pkg::CMD_INT_UNMASK, UNIT};
   localparam logic [7:0] C_MSK = {hbcsp_pkg::CMD_INT_MASK, UNIT};
   localparam logic [7:0] C_RD = {hbcsp_pkg::CMD_BYTE_READ, UNIT};
   localparam logic [7:0] C_WR = {hbcsp_pkg::CMD_BYTE_WRITE, UNIT};
   localparam logic [7:0] C_ST = {hbcsp_pkg::CMD_STATUS_READ, UNIT};
   localparam logic [7:0] C_RST = {hbcsp_pkg::CMD_RESET, UNIT};
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] cmdAddrPin, dataInPin, dataOut, wrByte, lastWr;
   logic cmdParityPin, strobe1Pin, strobe2Pin, dataOe, intReqOut, intAckPin;
   logic wrStrobe, rdStrobe, selectLatch, softReset, intMasked, endOfOp;
   logic seqIntEvent = 1'b0;
   logic seqSelClear = 1'b0;
   logic [7:0] seqRdByte = 8'h3c;
   hbcsp_pkg::hbcsp_seq_stat_t seqStat = '0;
   hbcsp_pkg::hbcsp_phase_t phase;
   hbcsp_pkg::hbcsp_status_t statusLatch;
   int failures = 0;
   int nTests = 0;
   int cycles = 0;
   int nWr = 0;
   int nRd = 0;
   int nEnd = 0;
   int nSoft = 0;

   // Free-running clock
   always #4 sys_clk = ~sys_clk;

   hbcsp_port u_dut (
      .sys_clk(sys_clk), .rstn(rstn), .cmdAddrPin(cmdAddrPin), .cmdParityPin(cmdParityPin),
      .strobe1Pin(strobe1Pin), .strobe2Pin(strobe2Pin), .dataInPin(dataInPin),
      .dataOut(dataOut), .dataOe(dataOe), .intReqOut(intReqOut), .intAckPin(intAckPin),
      .unitAddrStrap(UNIT), .parityDisableStrap(1'b0), .seqStat(seqStat),
      .seqRdByte(seqRdByte), .seqIntEvent(seqIntEvent), .seqSelClear(seqSelClear),
      .wrByte(wrByte), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .selectLatch(selectLatch),
      .softReset(softReset), .intMasked(intMasked), .endOfOp(endOfOp), .phase(phase),
      .statusLatch(statusLatch)
   );
   hbcsp_host_model u_host (
      .sys_clk(sys_clk), .cmdAddrPin(cmdAddrPin), .cmdParityPin(cmdParityPin),
      .strobe1Pin(strobe1Pin), .strobe2Pin(strobe2Pin), .dataInPin(dataInPin),
      .intAckPin(intAckPin)
   );

   // Pulse counters and hang guard
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      nWr <= nWr + int'(wrStrobe === 1'b1);
      nRd <= nRd + int'(rdStrobe === 1'b1);
      nEnd <= nEnd + int'(endOfOp === 1'b1);
      nSoft <= nSoft + int'(softReset === 1'b1);
      if (wrStrobe === 1'b1) lastWr <= wrByte;
      if (cycles == 5000) begin
         failures++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      nTests++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", nTests, failures);
      if (failures == 0 && nTests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // One command, data line drive checked while strobe is high
   task automatic cmd(input logic [7:0] ca, input logic [7:0] data, input logic bad,
      input logic alt, input logic oe, input logic [7:0] exp);
      u_host.issue(ca, data, bad, alt);
      chk(8'(dataOe), 8'(oe));
      if (oe) chk(dataOut, exp);
      u_host.release_bus();
   endtask

   // One interrupt acknowledge cycle
   task automatic ack(input logic [7:0] exp);
      u_host.set_ack(1'b1);
      chk(8'(dataOe), 8'h01);
      chk(dataOut, exp);
      u_host.set_ack(1'b0);
      chk(8'(intReqOut), 8'h00);
      chk(8'(dataOe), 8'h00);
   endtask

   task automatic pulse(ref logic s);
      @(negedge sys_clk);
      s = 1'b1;
      @(negedge sys_clk);
      s = 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask

   // Expected bus phase from {req, dir, cmdData, msg}
   function automatic hbcsp_pkg::hbcsp_phase_t expPh(input logic [3:0] v);
      if (!v[3] || v[2:0] == 3'b011) return hbcsp_pkg::PH_NONE;
      if (!v[1]) return v[2] ? hbcsp_pkg::PH_IN_DATA : hbcsp_pkg::PH_OUT_DATA;
      if (!v[2]) return hbcsp_pkg::PH_NEXT_CMD;
      return v[0] ? hbcsp_pkg::PH_MESSAGE : hbcsp_pkg::PH_COMPLETION;
   endfunction

   // Main sequence
   initial begin
      repeat (4) @(negedge sys_clk);
      rstn = 1'b1;
      repeat (6) @(negedge sys_clk);
      chk(8'(intMasked), 8'h01);
      chk(8'(selectLatch), 8'h00);
      cmd(C_ID, 8'h00, 0, 0, 1, hbcsp_pkg::IDENTITY_BYTE);
      cmd({hbcsp_pkg::CMD_IDENTITY_READ, ~UNIT}, 8'h00, 0, 0, 0, 8'h00);
      cmd(C_ID, 8'h00, 0, 1, 0, 8'h00);
      for (int c = 8; c < 16; c++) begin
         cmd({4'(c), UNIT}, 8'h00, 0, 0, 0, 8'h00);
      end
      chk(8'(intMasked), 8'h01);
      chk(8'(selectLatch), 8'h00);
      cmd(C_BEG, 8'h00, 0, 0, 0, 8'h00);
      chk(8'(selectLatch), 8'h01);
      pulse(seqSelClear);
      chk(8'(selectLatch), 8'h00);
      cmd(C_UNM, 8'h00, 0, 0, 0, 8'h00);
      chk(8'(intMasked), 8'h00);
      seqStat = 6'b101000;
      pulse(seqIntEvent);
      chk(8'(intReqOut), 8'h01);
      ack({4'b1010, UNIT});
      cmd(C_MSK, 8'h00, 0, 0, 0, 8'h00);
      pulse(seqIntEvent);
      chk(8'(intReqOut), 8'h00);
      seqStat = 6'b110111;
      cmd(C_ST, 8'h00, 0, 0, 1, 8'hd9);
      seqStat = 6'b001010;
      cmd(C_WR, 8'ha5, 0, 0, 0, 8'h00);
      chk(8'(nWr), 8'h01);
      chk(lastWr, 8'ha5);
      seqStat = 6'b101110;
      cmd(C_RD, 8'h00, 0, 0, 1, seqRdByte);
      chk(8'(nRd), 8'h01);
      chk(8'(nEnd), 8'h01);
      seqStat = 6'b000000;
      cmd(C_WR, 8'h11, 0, 0, 0, 8'h00);
      cmd(C_RD, 8'h00, 0, 0, 1, 8'h00);
      chk(8'(nWr + nRd), 8'h02);
      cmd(C_ST, 8'h00, 0, 0, 1, 8'h04);
      cmd(C_ID, 8'h00, 1, 0, 0, 8'h00);
      chk(8'(intReqOut), 8'h01);
      ack({4'b0100, UNIT});
      cmd(C_ST, 8'h00, 0, 0, 1, 8'h02);
      cmd(C_BEG, 8'h00, 0, 0, 0, 8'h00);
      cmd(C_UNM, 8'h00, 0, 0, 0, 8'h00);
      cmd(C_RST, 8'h00, 0, 0, 0, 8'h00);
      chk(8'(intMasked), 8'h01);
      chk(8'(selectLatch), 8'h00);
      chk(8'(nSoft), 8'h01);
      for (int i = 0; i < 16; i++) begin
         @(negedge sys_clk);
         seqStat = {i[2], 1'b0, i[1], i[0], i[3], 1'b0};
         #1 chk(8'(phase), 8'(expPh(4'(i))));
      end
      report_and_stop();
   end
endmodule
`default_nettype wire

// ---- rtl/hbcsp_port.sv ----
`default_nettype none
// Function
// - Command in high nibble, address low
// - Only strobe one qualifies commands
// - Eight four-bit command codes decoded
// - Byte read drives controller byte out
// - Byte write takes host byte in
// - Unmask clears, mask sets; parity unmaskable
// - Mask set after power-up and reset
// - Begin sets select; controller clears it
// - Identity read returns fixed byte
// - Status read drives status latch
// - Reset reinitialises, no diagnostics, drives untouched
// - Bit 7 transfer direction, valid with request
// - Bit 6 busy acknowledges begin
// - Bit 5 command or data
// - Bit 4 message; ending byte then idle
// - Bit 3 byte request qualifies others
// - Bit 2 set on unrequested read/write
// - Parity error ignores command, flags, interrupts
// - Bit 0 self-test running or failed
// - Bits 7,5,4 decode bus phase
// - Response byte: address, error, phase bits
// - Acknowledge completion clears request and response
module hbcsp_port (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Host command/address and strobes
   input wire logic [7:0] cmdAddrPin,
   input wire logic cmdParityPin,
   input wire logic strobe1Pin,
   input wire logic strobe2Pin,
   // Host data lines
   input wire logic [7:0] dataInPin,
   output logic [7:0] dataOut,
   output logic dataOe,
   // Host interrupt lines
   output logic intReqOut,
   input wire logic intAckPin,
   // Jumper straps
   input wire logic [3:0] unitAddrStrap,
   input wire logic parityDisableStrap,
   // Sequencer state and events
   input wire hbcsp_pkg::hbcsp_seq_stat_t seqStat,
   input wire logic [7:0] seqRdByte,
   input wire logic seqIntEvent,
   input wire logic seqSelClear,
   // Towards the sequencer
   output logic [7:0] wrByte,
   output logic wrStrobe,
   output logic rdStrobe,
   output logic selectLatch,
   output logic softReset,
   output logic intMasked,
   output logic endOfOp,
   output hbcsp_pkg::hbcsp_phase_t phase,
   output hbcsp_pkg::hbcsp_status_t statusLatch
);

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic [hbcsp_pkg::PIN_W-1:0] pinSync;
   logic [hbcsp_pkg::STRAP_W-1:0] strapSync;
   logic [7:0] cmdAddrS;
   logic [7:0] dataInS;
   logic parityS;
   logic strobeS;
   logic ackS;

   // Host pins arrive from outside the clock domain
   hbcsp_sync #(.W(hbcsp_pkg::PIN_W)) u_pin_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .d({cmdAddrPin, dataInPin, cmdParityPin, strobe1Pin, intAckPin}),
      .q(pinSync)
   );

   // Straps are static but still asynchronous to the clock
   hbcsp_sync #(.W(hbcsp_pkg::STRAP_W)) u_strap_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .d({unitAddrStrap, parityDisableStrap}),
      .q(strapSync)
   );

   // Split the synchronised pin vector
   assign cmdAddrS = pinSync[18:11];
   assign dataInS = pinSync[10:3];
   assign parityS = pinSync[2];
   assign strobeS = pinSync[1];
   assign ackS = pinSync[0];

   // ----------------------------------------------------------------
   // Strap capture and edge detection
   // ----------------------------------------------------------------
   logic [3:0] unitAddr_q;
   logic parityOff_q;
   logic strapDone_q;
   logic [1:0] settle_q;
   logic strobePrev_q;
   logic ackPrev_q;
   logic strobeRise;
   logic strobeFall;
   logic ackRise;
   logic ackFall;

   // Straps are caught once the synchroniser has settled after reset
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         unitAddr_q <= 4'h0;
         parityOff_q <= 1'b0;
         strapDone_q <= 1'b0;
      end else if (!strapDone_q && settle_q[1]) begin
         unitAddr_q <= strapSync[4:1];
         parityOff_q <= strapSync[0];
         strapDone_q <= 1'b1;
      end
   end

   // Previous levels for edge detection; settle marks two edges since reset
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         settle_q <= 2'h0;
         strobePrev_q <= 1'b0;
         ackPrev_q <= 1'b0;
      end else begin
         settle_q <= {settle_q[0], 1'b1};
         strobePrev_q <= strobeS;
         ackPrev_q <= ackS;
      end
   end

   // Strobe two is never looked at
   assign strobeRise = strobeS && !strobePrev_q && strapDone_q;
   assign strobeFall = !strobeS && strobePrev_q;
   assign ackRise = ackS && !ackPrev_q;
   assign ackFall = !ackS && ackPrev_q;

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   logic [3:0] cmdCode;
   logic addrHit;
   logic parityBad;
   logic cmdTake;
   logic isRead;
   logic isWrite;
   logic isReset;
   hbcsp_pkg::hbcsp_state_t state_q;

   // Code in the high nibble, unit address in the low nibble
   assign cmdCode = cmdAddrS[hbcsp_pkg::CMD_MSB:hbcsp_pkg::CMD_LSB];
   // Only our own jumper address is acted upon
   assign addrHit = cmdAddrS[hbcsp_pkg::ADDR_MSB:hbcsp_pkg::ADDR_LSB] == unitAddr_q;
   // Odd parity over command byte and parity line, any address
   assign parityBad = strobeRise && !parityOff_q && !(^{cmdAddrS, parityS});
   // Undefined codes with the top bit set fall out here
   assign cmdTake = strobeRise && !parityBad && addrHit
      && !cmdCode[hbcsp_pkg::UNDEF_BIT];
   assign isRead = cmdTake && cmdCode == hbcsp_pkg::CMD_BYTE_READ;
   assign isWrite = cmdTake && cmdCode == hbcsp_pkg::CMD_BYTE_WRITE;
   assign isReset = cmdTake && cmdCode == hbcsp_pkg::CMD_RESET;

   // ----------------------------------------------------------------
   // Interrupt mask
   // ----------------------------------------------------------------
   logic mask_q;

   // Mask comes up set at power-up and on the reset command
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         mask_q <= hbcsp_pkg::MASK_RST;
      end else if (isReset) begin
         mask_q <= hbcsp_pkg::MASK_RST;
      end else if (cmdTake && cmdCode == hbcsp_pkg::CMD_INT_UNMASK) begin
         mask_q <= 1'b0;
      end else if (cmdTake && cmdCode == hbcsp_pkg::CMD_INT_MASK) begin
         mask_q <= 1'b1;
      end
   end

   assign intMasked = mask_q;

   // ----------------------------------------------------------------
   // Select latch
   // ----------------------------------------------------------------
   logic select_q;

   // Begin sets the latch, sequencer clears it; the set wins
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         select_q <= hbcsp_pkg::SELECT_RST;
      end else if (isReset) begin
         select_q <= hbcsp_pkg::SELECT_RST;
      end else if (cmdTake && cmdCode == hbcsp_pkg::CMD_BEGIN_TRANS) begin
         select_q <= 1'b1;
      end else if (seqSelClear) begin
         select_q <= 1'b0;
      end
   end

   assign selectLatch = select_q;

   // ----------------------------------------------------------------
   // Sticky error flags
   // ----------------------------------------------------------------
   logic invalid_q;
   logic parity_q;
   logic invalidSet;
   logic statusRead;

   // Transfer commands without a pending byte request
   assign invalidSet = (isRead || isWrite) && !seqStat.req;
   assign statusRead = cmdTake && cmdCode == hbcsp_pkg::CMD_STATUS_READ;

   // Flags clear after a status read, a new error wins over the clear
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         invalid_q <= hbcsp_pkg::FLAG_RST;
         parity_q <= hbcsp_pkg::FLAG_RST;
      end else begin
         if (invalidSet) begin
            invalid_q <= 1'b1;
         end else if (statusRead || isReset) begin
            invalid_q <= 1'b0;
         end
         if (parityBad) begin
            parity_q <= 1'b1;
         end else if (statusRead || isReset) begin
            parity_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Status latch and phase decode
   // ----------------------------------------------------------------
   hbcsp_pkg::hbcsp_status_t status;

   // Latch view: sequencer state plus local flags
   always_comb begin
      status.dir = seqStat.dir;
      status.busy = seqStat.busy;
      status.cmdData = seqStat.cmdData;
      status.message_phase = seqStat.message_phase;
      status.req = seqStat.req;
      status.invalid = invalid_q;
      status.parity = parity_q;
      status.selftest = seqStat.selftest;
   end

   assign statusLatch = status;

   // Phase bits only mean something while a byte is requested
   always_comb begin
      phase = hbcsp_pkg::PH_NONE;
      if (status.req) begin
         unique case ({status.dir, status.cmdData, status.message_phase})
            3'b010: phase = hbcsp_pkg::PH_NEXT_CMD;
            3'b000, 3'b001: phase = hbcsp_pkg::PH_OUT_DATA;
            3'b100, 3'b101: phase = hbcsp_pkg::PH_IN_DATA;
            3'b110: phase = hbcsp_pkg::PH_COMPLETION;
            3'b111: phase = hbcsp_pkg::PH_MESSAGE;
            3'b011: phase = hbcsp_pkg::PH_NONE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Interrupt request
   // ----------------------------------------------------------------
   logic intPend_q;
   logic intSet;
   hbcsp_pkg::hbcsp_resp_t resp;

   // Mask blocks all sources except a parity error
   assign intSet = parityBad || (!mask_q && (seqIntEvent || invalidSet));

   // Acknowledge completion clears the request; a new event wins
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         intPend_q <= 1'b0;
      end else if (intSet) begin
         intPend_q <= 1'b1;
      end else if (isReset) begin
         intPend_q <= 1'b0;
      end else if (state_q == hbcsp_pkg::DS_RESP && ackFall) begin
         intPend_q <= 1'b0;
      end
   end

   assign intReqOut = intPend_q;

   // Response byte contents
   always_comb begin
      resp.dir = status.dir;
      resp.err = status.parity || status.invalid;
      resp.cmdData = status.cmdData;
      resp.message_phase = status.message_phase;
      resp.unit = unitAddr_q;
   end

   // ----------------------------------------------------------------
   // Data line driver
   // ----------------------------------------------------------------
   logic [7:0] dataOut_q;
   logic takeResp;
   logic driveCmd;

   // Acknowledge of a pending request outranks a same-cycle read
   assign takeResp = ackRise && intPend_q;
   assign driveCmd = cmdTake && (cmdCode == hbcsp_pkg::CMD_BYTE_READ
      || cmdCode == hbcsp_pkg::CMD_IDENTITY_READ
      || cmdCode == hbcsp_pkg::CMD_STATUS_READ);

   // Drive state: hold the byte while the strobe or acknowledge stands
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= hbcsp_pkg::DS_IDLE;
      end else begin
         unique case (state_q)
            hbcsp_pkg::DS_IDLE: begin
               if (takeResp) begin
                  state_q <= hbcsp_pkg::DS_RESP;
               end else if (driveCmd) begin
                  state_q <= hbcsp_pkg::DS_DRIVE;
               end
            end
            hbcsp_pkg::DS_DRIVE: begin
               if (strobeFall) begin
                  state_q <= hbcsp_pkg::DS_IDLE;
               end
            end
            hbcsp_pkg::DS_RESP: begin
               if (ackFall) begin
                  state_q <= hbcsp_pkg::DS_IDLE;
               end
            end
            default: state_q <= hbcsp_pkg::DS_IDLE;
         endcase
      end
   end

   // Byte placed on the data lines
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         dataOut_q <= hbcsp_pkg::DATA_RST;
      end else if (state_q == hbcsp_pkg::DS_IDLE && takeResp) begin
         dataOut_q <= resp;
      end else if (state_q == hbcsp_pkg::DS_IDLE && driveCmd) begin
         unique case (cmdCode)
            hbcsp_pkg::CMD_BYTE_READ:
               dataOut_q <= seqStat.req ? seqRdByte : hbcsp_pkg::INVALID_FILL;
            hbcsp_pkg::CMD_IDENTITY_READ: dataOut_q <= hbcsp_pkg::IDENTITY_BYTE;
            default: dataOut_q <= status;
         endcase
      end else if (state_q == hbcsp_pkg::DS_RESP && ackFall) begin
         dataOut_q <= hbcsp_pkg::DATA_RST;
      end
   end

   assign dataOut = dataOut_q;
   assign dataOe = state_q != hbcsp_pkg::DS_IDLE;

   // ----------------------------------------------------------------
   // Sequencer handshakes
   // ----------------------------------------------------------------
   logic [7:0] wrByte_q;
   logic wrStrobe_q;
   logic rdStrobe_q;
   logic softReset_q;
   logic endOfOp_q;

   // Host byte taken into the controller when requested
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wrByte_q <= hbcsp_pkg::DATA_RST;
      end else if (isWrite && seqStat.req) begin
         wrByte_q <= dataInS;
      end
   end

   // One-cycle pulses to the sequencer
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wrStrobe_q <= 1'b0;
         rdStrobe_q <= 1'b0;
         softReset_q <= 1'b0;
         endOfOp_q <= 1'b0;
      end else begin
         wrStrobe_q <= isWrite && seqStat.req;
         rdStrobe_q <= isRead && seqStat.req && !takeResp;
         // Reinitialise only; no self-test, drives left alone
         softReset_q <= isReset;
         // Ending byte moved with message, request and direction set
         endOfOp_q <= isRead && !takeResp && seqStat.req && seqStat.message_phase && seqStat.dir;
      end
   end

   assign wrByte = wrByte_q;
   assign wrStrobe = wrStrobe_q;
   assign rdStrobe = rdStrobe_q;
   assign softReset = softReset_q;
   assign endOfOp = endOfOp_q;

endmodule
`default_nettype wire

// ---- rtl/hbcsp_sync.sv ----
`default_nettype none
module hbcsp_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // Two-stage synchroniser, first stage read only by the second
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;

endmodule
`default_nettype wire
